// file: rtl/emf_params.svh
`ifndef EMF_PARAMS_SVH
`define EMF_PARAMS_SVH

// ----------------------------------------------------------------------
// message layout
// ----------------------------------------------------------------------
`define EMF_WORDS          5
`define EMF_LAST_IDX       3'h4
`define EMF_SUB_LSB        0
`define EMF_SUB_W          6
`define EMF_CLASS_LSB      6
`define EMF_IDENT_LSB      8
`define EMF_CAT_W          14
`define EMF_CAT_DEPTH      16384
`define EMF_TCP_SPARE      8'h00

// ----------------------------------------------------------------------
// hold-off per category, in seconds of the time base
// ----------------------------------------------------------------------
`define EMF_HOLDOFF_S      10
`define EMF_TICKS_PER_S    1

// ----------------------------------------------------------------------
// rejected command group: identifier / sub-field
// ----------------------------------------------------------------------
`define EMF_ID_TC_TYPE     8'h80
`define EMF_ID_TC_TASK     8'h81
`define EMF_ID_TC_MODULE   8'h82
`define EMF_ID_TC_ADDR     8'h83
`define EMF_ID_TC_LEN      8'h84
`define EMF_ID_TC_OTHER    8'h85
`define EMF_ID_TC_QFULL    8'h86
`define EMF_ID_TC_HWSD     8'h87
`define EMF_ID_TC_STSD     8'h88
`define EMF_ID_TC_EXEC     8'h89
`define EMF_ID_TC_FIRE     8'h8A
`define EMF_SF_TC_TYPE     6'h01
`define EMF_SF_TC_TASK     6'h02
`define EMF_SF_TC_MODULE   6'h03
`define EMF_SF_TC_ADDR     6'h04
`define EMF_SF_TC_LEN      6'h05
`define EMF_SF_TC_OTHER    6'h06
`define EMF_SF_TC_QFULL    6'h07
`define EMF_SF_TC_HWSD     6'h08
`define EMF_SF_TC_STSD     6'h09
`define EMF_SF_TC_EXEC     6'h0A
`define EMF_SF_TC_FIRE     6'h1F

// ----------------------------------------------------------------------
// fast serial link group: identifier / sub-field
// ----------------------------------------------------------------------
`define EMF_ID_FSL_OVF     8'h97
`define EMF_ID_FSL_CRC     8'h9E
`define EMF_ID_FSL_TMO     8'h9F
`define EMF_ID_FSL_SYNC    8'h9A
`define EMF_SF_FSL_OVF     6'h01
`define EMF_SF_FSL_CRC     6'h08
`define EMF_SF_FSL_TMO     6'h09
`define EMF_SF_FSL_SYNC    6'h0B

`endif

// file: rtl/emf_pkg.sv
package emf_pkg;

   // ----------------------------------------------------------------------
   // message class codes
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      EMF_CLASS_EVENT     = 2'h0,
      EMF_CLASS_EXCEPTION = 2'h1,
      EMF_CLASS_MAJOR     = 2'h2,
      EMF_CLASS_FAILED_TC = 2'h3
   } emf_class_e;

   // ----------------------------------------------------------------------
   // fault codes encoded by the block itself
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      EMF_F_TC_TYPE   = 4'h0,
      EMF_F_TC_TASK   = 4'h1,
      EMF_F_TC_MODULE = 4'h2,
      EMF_F_TC_ADDR   = 4'h3,
      EMF_F_TC_LEN    = 4'h4,
      EMF_F_TC_OTHER  = 4'h5,
      EMF_F_TC_QFULL  = 4'h6,
      EMF_F_TC_HWSD   = 4'h7,
      EMF_F_TC_STSD   = 4'h8,
      EMF_F_TC_EXEC   = 4'h9,
      EMF_F_TC_FIRE   = 4'hA,
      EMF_F_FSL_OVF   = 4'hB,
      EMF_F_FSL_CRC   = 4'hC,
      EMF_F_FSL_TMO   = 4'hD,
      EMF_F_FSL_SYNC  = 4'hE
   } emf_fault_e;

   // ----------------------------------------------------------------------
   // control states, gray along init-idle-look-check-send
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      EMF_ST_INIT  = 3'h0,
      EMF_ST_IDLE  = 3'h1,
      EMF_ST_LOOK  = 3'h3,
      EMF_ST_CHECK = 3'h2,
      EMF_ST_SEND  = 3'h6
   } emf_state_e;

endpackage

// file: rtl/emf_code_encoder.sv
`timescale 1ns/1ps
`include "emf_params.svh"

module emf_code_encoder (
   input  wire  logic [3:0]  fault_code,
   input  wire  logic [15:0] tc_header,
   input  wire  logic [3:0]  tc_type,
   input  wire  logic [3:0]  tc_subtype,
   output logic       [7:0]  enc_ident,
   output logic       [5:0]  enc_sub,
   output logic       [1:0]  enc_class,
   output logic       [15:0] enc_param0,
   output logic       [15:0] enc_param1
);

   // ----------------------------------------------------------------------
   // fault code to category, class and parameters
   // ----------------------------------------------------------------------
   always_comb begin
      enc_class  = emf_pkg::EMF_CLASS_FAILED_TC;
      enc_param0 = tc_header;
      enc_param1 = {tc_subtype, tc_type, `EMF_TCP_SPARE};
      enc_ident  = `EMF_ID_TC_OTHER;
      enc_sub    = `EMF_SF_TC_OTHER;
      unique case (emf_pkg::emf_fault_e'(fault_code))
         emf_pkg::EMF_F_TC_TYPE: begin
            enc_ident = `EMF_ID_TC_TYPE;
            enc_sub   = `EMF_SF_TC_TYPE;
         end
         emf_pkg::EMF_F_TC_TASK: begin
            enc_ident = `EMF_ID_TC_TASK;
            enc_sub   = `EMF_SF_TC_TASK;
         end
         emf_pkg::EMF_F_TC_MODULE: begin
            enc_ident = `EMF_ID_TC_MODULE;
            enc_sub   = `EMF_SF_TC_MODULE;
         end
         emf_pkg::EMF_F_TC_ADDR: begin
            enc_ident = `EMF_ID_TC_ADDR;
            enc_sub   = `EMF_SF_TC_ADDR;
         end
         emf_pkg::EMF_F_TC_LEN: begin
            enc_ident = `EMF_ID_TC_LEN;
            enc_sub   = `EMF_SF_TC_LEN;
         end
         emf_pkg::EMF_F_TC_OTHER: begin
            enc_ident = `EMF_ID_TC_OTHER;
            enc_sub   = `EMF_SF_TC_OTHER;
         end
         emf_pkg::EMF_F_TC_QFULL: begin
            enc_ident = `EMF_ID_TC_QFULL;
            enc_sub   = `EMF_SF_TC_QFULL;
         end
         emf_pkg::EMF_F_TC_HWSD: begin
            enc_ident = `EMF_ID_TC_HWSD;
            enc_sub   = `EMF_SF_TC_HWSD;
         end
         emf_pkg::EMF_F_TC_STSD: begin
            enc_ident = `EMF_ID_TC_STSD;
            enc_sub   = `EMF_SF_TC_STSD;
         end
         emf_pkg::EMF_F_TC_EXEC: begin
            enc_ident = `EMF_ID_TC_EXEC;
            enc_sub   = `EMF_SF_TC_EXEC;
         end
         emf_pkg::EMF_F_TC_FIRE: begin
            enc_ident  = `EMF_ID_TC_FIRE;
            enc_sub    = `EMF_SF_TC_FIRE;
            enc_param0 = 16'h0000;
            enc_param1 = 16'h0000;
         end
         emf_pkg::EMF_F_FSL_OVF: begin
            enc_ident  = `EMF_ID_FSL_OVF;
            enc_sub    = `EMF_SF_FSL_OVF;
            enc_class  = emf_pkg::EMF_CLASS_MAJOR;
            enc_param0 = 16'h0000;
            enc_param1 = 16'h0000;
         end
         emf_pkg::EMF_F_FSL_CRC: begin
            enc_ident  = `EMF_ID_FSL_CRC;
            enc_sub    = `EMF_SF_FSL_CRC;
            enc_class  = emf_pkg::EMF_CLASS_MAJOR;
            enc_param0 = 16'h0000;
            enc_param1 = 16'h0000;
         end
         emf_pkg::EMF_F_FSL_TMO: begin
            enc_ident  = `EMF_ID_FSL_TMO;
            enc_sub    = `EMF_SF_FSL_TMO;
            enc_class  = emf_pkg::EMF_CLASS_MAJOR;
            enc_param0 = 16'h0000;
            enc_param1 = 16'h0000;
         end
         emf_pkg::EMF_F_FSL_SYNC: begin
            enc_ident  = `EMF_ID_FSL_SYNC;
            enc_sub    = `EMF_SF_FSL_SYNC;
            enc_class  = emf_pkg::EMF_CLASS_EVENT;
            enc_param0 = 16'h0000;
            enc_param1 = 16'h0000;
         end
         default: begin
            enc_ident = `EMF_ID_TC_OTHER;
            enc_sub   = `EMF_SF_TC_OTHER;
         end
      endcase
   end

endmodule // emf_code_encoder

// file: rtl/emf_word_shifter.sv
`timescale 1ns/1ps
`include "emf_params.svh"

module emf_word_shifter (
   input  wire  logic        ref_clk,
   input  wire  logic        resetn,
   input  wire  logic        load,
   input  wire  logic [31:0] msg_time,
   input  wire  logic [15:0] msg_word2,
   input  wire  logic [15:0] msg_param0,
   input  wire  logic [15:0] msg_param1,
   input  wire  logic        out_ready,
   output logic              out_valid,
   output logic       [15:0] out_word,
   output logic       [2:0]  out_index,
   output logic              out_last
);

   logic [15:0] words_reg [0:`EMF_WORDS-1];
   logic [15:0] load_word [0:`EMF_WORDS-1];
   logic        advance;

   // ----------------------------------------------------------------------
   // five words: time high, time low, category word, two parameters
   // ----------------------------------------------------------------------
   assign load_word[0] = msg_time[31:16];
   assign load_word[1] = msg_time[15:0];
   assign load_word[2] = msg_word2;
   assign load_word[3] = msg_param0;
   assign load_word[4] = msg_param1;
   assign advance      = out_valid && out_ready;

   genvar gi;
   generate
      for (gi = 0; gi < `EMF_WORDS; gi++) begin : g_word
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               words_reg[gi] <= 16'h0000;
            end else if (load) begin
               words_reg[gi] <= load_word[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // output sequencing
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         out_valid <= 1'b0;
         out_index <= 3'h0;
         out_word  <= 16'h0000;
         out_last  <= 1'b0;
      end else if (load) begin
         out_valid <= 1'b1;
         out_index <= 3'h0;
         out_word  <= load_word[0];
         out_last  <= 1'b0;
      end else if (advance) begin
         if (out_index == `EMF_LAST_IDX) begin
            out_valid <= 1'b0;
            out_last  <= 1'b0;
         end else begin
            out_index <= out_index + 3'h1;
            out_word  <= words_reg[out_index + 3'h1];
            out_last  <= (out_index + 3'h1) == `EMF_LAST_IDX;
         end
      end
   end

endmodule // emf_word_shifter

// file: rtl/emf_top.sv
`timescale 1ns/1ps
`include "emf_params.svh"

// What this block does
// - each message is five 16-bit words; words 0 and 1 hold issue time
// - word 2: sub-field bits 0-5, class bits 6-7, identifier bits 8-15
// - words 3 and 4 carry category parameters, zero when unused
// - identifier joined with sub-field forms the category used for filtering
// - last actually issued time is stored for every category
// - issue only if ten seconds passed since last issue in category
// - rejected command: header in word 3, type/subtype packed in word 4
// - parse failures: class 3, identifiers 128-133, sub-fields 1-6
// - full command queue: class 3, identifier 134, sub-field 7
// - shutdown rejects: hardware 135/8, state change 136/9, class 3
// - accepted command failing in execution: class 3, 137/10
// - fire without arm: class 3, 138/31, both parameters zero
// - link faults: overflow 151/1, checksum 158/8, timeout 159/9, sync loss 154/11

module emf_top #(
   parameter int TIME_TICKS_PER_S = `EMF_TICKS_PER_S
) (
   input  wire  logic        ref_clk,
   input  wire  logic        resetn,
   input  wire  logic [31:0] time_now,
   input  wire  logic        req_valid,
   output logic              req_ready,
   input  wire  logic [7:0]  req_ident,
   input  wire  logic [5:0]  req_sub,
   input  wire  logic [1:0]  req_class,
   input  wire  logic [15:0] req_param0,
   input  wire  logic [15:0] req_param1,
   input  wire  logic        req_use0,
   input  wire  logic        req_use1,
   input  wire  logic        fault_valid,
   output logic              fault_ready,
   input  wire  logic [3:0]  fault_code,
   input  wire  logic [15:0] fault_tc_header,
   input  wire  logic [3:0]  fault_tc_type,
   input  wire  logic [3:0]  fault_tc_subtype,
   output logic              out_valid,
   input  wire  logic        out_ready,
   output logic       [15:0] out_word,
   output logic       [2:0]  out_index,
   output logic              out_last,
   output logic              issued_pulse,
   output logic              blocked_pulse,
   output logic       [15:0] issued_count,
   output logic       [15:0] blocked_count,
   output logic              init_busy
);

   localparam logic [31:0] HOLDOFF_TICKS = 32'(`EMF_HOLDOFF_S * TIME_TICKS_PER_S);
   localparam logic [13:0] CAT_LAST      = 14'(`EMF_CAT_DEPTH - 1);

   emf_pkg::emf_state_e state_reg;
   emf_pkg::emf_state_e state_next;

   logic [31:0] last_time_mem [0:`EMF_CAT_DEPTH-1];
   logic        seen_mem      [0:`EMF_CAT_DEPTH-1];

   logic [13:0] sweep_reg;
   logic [13:0] cat_reg;
   logic [31:0] stamp_reg;
   logic [15:0] word2_reg;
   logic [15:0] param0_reg;
   logic [15:0] param1_reg;
   logic [31:0] rd_time_reg;
   logic        rd_seen_reg;

   logic [7:0]  enc_ident;
   logic [5:0]  enc_sub;
   logic [1:0]  enc_class;
   logic [15:0] enc_param0;
   logic [15:0] enc_param1;

   logic        take_fault;
   logic        take_req;
   logic        take_any;
   logic [7:0]  sel_ident;
   logic [5:0]  sel_sub;
   logic [1:0]  sel_class;
   logic [15:0] sel_param0;
   logic [15:0] sel_param1;
   logic [31:0] elapsed;
   logic        allow;
   logic        issue;
   logic        block;
   logic        mem_we;
   logic [13:0] mem_addr;
   logic        send_done;

   // ----------------------------------------------------------------------
   // fault encoding
   // ----------------------------------------------------------------------
   emf_code_encoder u_encoder (
      .fault_code (fault_code),
      .tc_header  (fault_tc_header),
      .tc_type    (fault_tc_type),
      .tc_subtype (fault_tc_subtype),
      .enc_ident  (enc_ident),
      .enc_sub    (enc_sub),
      .enc_class  (enc_class),
      .enc_param0 (enc_param0),
      .enc_param1 (enc_param1)
   );

   // ----------------------------------------------------------------------
   // request acceptance; encoded faults win over generic requests
   // ----------------------------------------------------------------------
   assign fault_ready = (state_reg == emf_pkg::EMF_ST_IDLE);
   assign req_ready   = (state_reg == emf_pkg::EMF_ST_IDLE) && !fault_valid;
   assign take_fault  = fault_valid && fault_ready;
   assign take_req    = req_valid && req_ready;
   assign take_any    = take_fault || take_req;

   always_comb begin
      if (take_fault) begin
         sel_ident  = enc_ident;
         sel_sub    = enc_sub;
         sel_class  = enc_class;
         sel_param0 = enc_param0;
         sel_param1 = enc_param1;
      end else begin
         sel_ident  = req_ident;
         sel_sub    = req_sub;
         sel_class  = req_class;
         sel_param0 = req_use0 ? req_param0 : 16'h0000;
         sel_param1 = req_use1 ? req_param1 : 16'h0000;
      end
   end

   // ----------------------------------------------------------------------
   // latched message fields
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cat_reg    <= 14'h0000;
         stamp_reg  <= 32'h0000_0000;
         word2_reg  <= 16'h0000;
         param0_reg <= 16'h0000;
         param1_reg <= 16'h0000;
      end else if (take_any) begin
         cat_reg    <= {sel_ident, sel_sub};
         stamp_reg  <= time_now;
         word2_reg  <= {sel_ident, sel_class, sel_sub};
         param0_reg <= sel_param0;
         param1_reg <= sel_param1;
      end
   end

   // ----------------------------------------------------------------------
   // hold-off decision
   // ----------------------------------------------------------------------
   // wrapping subtraction keeps the hold-off right across a time base rollover
   assign elapsed = stamp_reg - rd_time_reg;
   assign allow   = !rd_seen_reg || (elapsed >= HOLDOFF_TICKS);
   assign issue   = (state_reg == emf_pkg::EMF_ST_CHECK) && allow;
   assign block   = (state_reg == emf_pkg::EMF_ST_CHECK) && !allow;

   // ----------------------------------------------------------------------
   // per-category issue time store; swept clear after reset
   // ----------------------------------------------------------------------
   assign mem_we   = init_busy || issue;
   assign mem_addr = init_busy ? sweep_reg : cat_reg;

   // a blocked request writes nothing, so its category keeps the older time
   always_ff @(posedge ref_clk) begin
      if (mem_we) begin
         last_time_mem[mem_addr] <= stamp_reg;
         seen_mem[mem_addr]      <= !init_busy;
      end
   end

   // stored time of the latched category, settled before the decision cycle
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rd_time_reg <= 32'h0000_0000;
         rd_seen_reg <= 1'b0;
      end else begin
         rd_time_reg <= last_time_mem[cat_reg];
         rd_seen_reg <= seen_mem[cat_reg];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sweep_reg <= 14'h0000;
      end else if (init_busy) begin
         sweep_reg <= sweep_reg + 14'h0001;
      end
   end

   // ----------------------------------------------------------------------
   // control sequence
   // ----------------------------------------------------------------------
   assign send_done = !out_valid;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         emf_pkg::EMF_ST_INIT: begin
            if (sweep_reg == CAT_LAST) begin
               state_next = emf_pkg::EMF_ST_IDLE;
            end
         end
         emf_pkg::EMF_ST_IDLE: begin
            if (take_any) begin
               state_next = emf_pkg::EMF_ST_LOOK;
            end
         end
         emf_pkg::EMF_ST_LOOK: begin
            state_next = emf_pkg::EMF_ST_CHECK;
         end
         emf_pkg::EMF_ST_CHECK: begin
            if (allow) begin
               state_next = emf_pkg::EMF_ST_SEND;
            end else begin
               state_next = emf_pkg::EMF_ST_IDLE;
            end
         end
         emf_pkg::EMF_ST_SEND: begin
            if (send_done) begin
               state_next = emf_pkg::EMF_ST_IDLE;
            end
         end
         default: begin
            state_next = emf_pkg::EMF_ST_INIT;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg <= emf_pkg::EMF_ST_INIT;
      end else begin
         state_reg <= state_next;
      end
   end

   // busy flag comes straight from a flip-flop and tracks the init state
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         init_busy <= 1'b1;
      end else begin
         init_busy <= (state_next == emf_pkg::EMF_ST_INIT);
      end
   end

   // ----------------------------------------------------------------------
   // word output
   // ----------------------------------------------------------------------
   emf_word_shifter u_shifter (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .load       (issue),
      .msg_time   (stamp_reg),
      .msg_word2  (word2_reg),
      .msg_param0 (param0_reg),
      .msg_param1 (param1_reg),
      .out_ready  (out_ready),
      .out_valid  (out_valid),
      .out_word   (out_word),
      .out_index  (out_index),
      .out_last   (out_last)
   );

   // ----------------------------------------------------------------------
   // status pulses and saturating counters
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         issued_pulse <= 1'b0;
      end else begin
         issued_pulse <= issue;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         blocked_pulse <= 1'b0;
      end else begin
         blocked_pulse <= block;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         issued_count <= 16'h0000;
      end else if (issue && issued_count != 16'hFFFF) begin
         issued_count <= issued_count + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         blocked_count <= 16'h0000;
      end else if (block && blocked_count != 16'hFFFF) begin
         blocked_count <= blocked_count + 16'h0001;
      end
   end

endmodule // emf_top

// file: tb/emf_top_asserts.sv
`timescale 1ns/1ps
module emf_top_asserts (
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic [31:0] time_now,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic        fault_valid,
   input wire logic        fault_ready,
   input wire logic        out_valid,
   input wire logic        out_ready,
   input wire logic [15:0] out_word,
   input wire logic [2:0]  out_index,
   input wire logic        out_last,
   input wire logic        issued_pulse,
   input wire logic        blocked_pulse,
   input wire logic        init_busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic take;
   assign take = (req_valid && req_ready) || (fault_valid && fault_ready);
   // ---------------------------------------------------------------
   // output framing
   // ---------------------------------------------------------------
   chk_word_hold: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_word) && $stable(out_index))
      else $error("word moved while stalled");
   chk_index_step: assert property (
      out_valid && out_ready && !out_last |=> out_valid && out_index == $past(out_index) + 3'h1)
      else $error("word index did not step by one");
   chk_last_word: assert property (out_valid |-> out_last == (out_index == 3'h4))
      else $error("last flag not on word four");
   chk_first_word: assert property (issued_pulse |-> out_valid && out_index == 3'h0)
      else $error("message did not start at word zero");
   chk_stamp_high: assert property (
      take ##3 issued_pulse |-> out_word == $past(time_now[31:16], 3))
      else $error("word zero is not the stamp high half");
   chk_end_release: assert property (out_valid && out_ready && out_last |=> !out_valid)
      else $error("valid held after last word");
   chk_answer_time: assert property (take |-> ##3 (issued_pulse ^ blocked_pulse))
      else $error("no single answer three cycles after take");
   chk_block_quiet: assert property (blocked_pulse |-> !out_valid && !issued_pulse)
      else $error("blocked request produced output");
   chk_busy_refuse: assert property (
      out_valid || init_busy |-> !req_ready && !fault_ready)
      else $error("request accepted while busy");
   cover property (issued_pulse);
   cover property (blocked_pulse);
   cover property (out_valid && !out_ready ##1 out_valid && out_ready);
endmodule // emf_top_asserts

bind emf_top emf_top_asserts u_chk (.ref_clk(ref_clk), .resetn(resetn), .time_now(time_now),
   .req_valid(req_valid), .req_ready(req_ready), .fault_valid(fault_valid),
   .fault_ready(fault_ready), .out_valid(out_valid), .out_ready(out_ready),
   .out_word(out_word), .out_index(out_index), .out_last(out_last),
   .issued_pulse(issued_pulse), .blocked_pulse(blocked_pulse), .init_busy(init_busy));

// file: tb/emf_hk_sink.sv
`timescale 1ns/1ps
module emf_hk_sink (
   input  wire logic        ref_clk,
   input  wire logic        slow,
   input  wire logic        out_valid,
   input  wire logic [15:0] out_word,
   input  wire logic [2:0]  out_index,
   input  wire logic        out_last,
   output logic             out_ready,
   output logic [15:0]      words [5],
   output int               msg_cnt
);
   logic phase;
   initial phase = 1'b0;
   initial msg_cnt = 0;
   // slow mode accepts only every other cycle
   always @(posedge ref_clk) phase <= ~phase;
   assign out_ready = !slow || phase;
   always @(posedge ref_clk) begin
      if (out_valid && out_ready) begin
         words[out_index] <= out_word;
         if (out_last) msg_cnt <= msg_cnt + 1;
      end
   end
endmodule // emf_hk_sink

// file: tb/emf_top_tb.sv
`timescale 1ns/1ps
module emf_top_tb;
   logic ref_clk, resetn, req_valid, req_ready, fault_valid, fault_ready, slow;
   logic out_valid, out_ready, out_last, issued_pulse, blocked_pulse, init_busy;
   logic u0, u1;
   logic [31:0] tnow;
   logic [15:0] p0, p1, hdr, out_word, issued_count, blocked_count;
   logic [15:0] words [5];
   logic [7:0]  id;
   logic [5:0]  sf;
   logic [3:0]  fcode;
   logic [2:0]  out_index;
   logic [1:0]  cl;
   int          msg_cnt, miscompares, checks_done, n;
   logic [7:0]  f_id [15] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
                              8'h88, 8'h89, 8'h8A, 8'h97, 8'h9E, 8'h9F, 8'h9A};
   logic [5:0]  f_sf [15] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
                              6'h09, 6'h0A, 6'h1F, 6'h01, 6'h08, 6'h09, 6'h0B};

   emf_top #(.TIME_TICKS_PER_S(1)) dut (.ref_clk(ref_clk), .resetn(resetn), .time_now(tnow),
      .req_valid(req_valid), .req_ready(req_ready), .req_ident(id), .req_sub(sf),
      .req_class(cl), .req_param0(p0), .req_param1(p1), .req_use0(u0), .req_use1(u1),
      .fault_valid(fault_valid), .fault_ready(fault_ready), .fault_code(fcode),
      .fault_tc_header(hdr), .fault_tc_type(4'h3), .fault_tc_subtype(4'h6),
      .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
      .out_index(out_index), .out_last(out_last), .issued_pulse(issued_pulse),
      .blocked_pulse(blocked_pulse), .issued_count(issued_count),
      .blocked_count(blocked_count), .init_busy(init_busy));
   emf_hk_sink sink (.ref_clk(ref_clk), .slow(slow), .out_valid(out_valid),
      .out_word(out_word), .out_index(out_index), .out_last(out_last),
      .out_ready(out_ready), .words(words), .msg_cnt(msg_cnt));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic test_done;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one request, then wait for a whole message or a blocked answer
   task automatic go(input logic flt, input logic iss, input logic [15:0] e2, e3, e4);
      logic [15:0] e [5];
      int c0;
      c0 = msg_cnt;
      e = '{tnow[31:16], tnow[15:0], e2, e3, e4};
      n = 0;
      while (!(flt ? fault_ready : req_ready) && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      fault_valid = flt;
      req_valid = !flt;
      @(negedge ref_clk);
      fault_valid = 1'b0;
      req_valid = 1'b0;
      while (msg_cnt == c0 && blocked_pulse !== 1'b1 && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 300) begin
         miscompares++;
         $display("wrong value at %0t: no answer to request", $time);
         test_done();
      end
      chk({15'h0, blocked_pulse}, {15'h0, !iss});
      chk(16'(msg_cnt - c0), {15'h0, iss});
      for (int k = 0; k < 5 && iss; k++) chk(words[k], e[k]);
   endtask

   initial begin
      {resetn, req_valid, fault_valid, slow, u0, u1, fcode, cl, id, sf, p0, p1} = '0;
      {miscompares, checks_done} = '0;
      tnow = 32'h0012_0064;
      hdr = 16'h1238;
      repeat (5) @(negedge ref_clk);
      resetn = 1'b1;
      n = 0;
      while (init_busy !== 1'b0 && n < 20000) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 20000) begin
         miscompares++;
         $display("wrong value at %0t: clear sweep never ended", $time);
         test_done();
      end
      for (int i = 0; i < 15; i++) begin
         fcode = i[3:0];
         slow = i[0];
         go(1'b1, 1'b1, {f_id[i], (i < 11 ? 2'h3 : i < 14 ? 2'h2 : 2'h0), f_sf[i]},
            i < 10 ? hdr : 16'h0000, i < 10 ? 16'h6300 : 16'h0000);
      end
      fcode = 4'h0;
      tnow = 32'h0012_0069;
      go(1'b1, 1'b0, 16'h0, 16'h0, 16'h0);
      tnow = 32'h0012_006D;
      go(1'b1, 1'b0, 16'h0, 16'h0, 16'h0);
      tnow = 32'h0012_006E;
      go(1'b1, 1'b1, 16'h80C1, hdr, 16'h6300);
      {id, sf, cl, p0, p1, u0, u1} = {8'h01, 6'h05, 2'h1, 16'h1234, 16'h5678, 2'b10};
      go(1'b0, 1'b1, 16'h0145, 16'h1234, 16'h0000);
      {sf, u0, u1} = {6'h06, 2'b01};
      go(1'b0, 1'b1, 16'h0146, 16'h0000, 16'h5678);
      sf = 6'h05;
      go(1'b0, 1'b0, 16'h0, 16'h0, 16'h0);
      chk(issued_count, 16'h0012);
      chk(blocked_count, 16'h0003);
      test_done();
   end
endmodule // emf_top_tb
